// ### src/ipx_pkg.sv
// Constants and types shared by the interrupt priority controller
package ipx_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] IPX_OFF_PRIO1 = 8'h00;
  localparam logic [7:0] IPX_OFF_PRIO2 = 8'h04;
  localparam logic [7:0] IPX_OFF_PRIO3 = 8'h08;
  localparam logic [7:0] IPX_OFF_RSTCTL = 8'h0c;
  localparam logic [7:0] IPX_OFF_MAIN = 8'h10;
  localparam logic [7:0] IPX_OFF_SECOND = 8'h14;
  localparam logic [7:0] IPX_OFF_THIRD = 8'h18;
  // ==========================================================
  // Reset values and implemented-bit masks
  localparam logic [7:0] IPX_RST_PRIO1 = 8'hff;
  localparam logic [7:0] IPX_RST_PRIO2 = 8'hcf;
  localparam logic [7:0] IPX_RST_PRIO3 = 8'h31;
  localparam logic [7:0] IPX_RST_RSTCTL = 8'h5c;
  localparam logic [7:0] IPX_RST_MAIN = 8'h00;
  localparam logic [7:0] IPX_RST_SECOND = 8'hf7;
  localparam logic [7:0] IPX_RST_THIRD = 8'hc0;
  localparam logic [7:0] IPX_MASK_PRIO2 = 8'hcf;
  localparam logic [7:0] IPX_MASK_PRIO3 = 8'h31;
  localparam logic [7:0] IPX_WMASK_PRIO3 = 8'h01;
  localparam logic [7:0] IPX_WMASK_RSTCTL = 8'hd3;
  // ==========================================================
  // Field positions
  localparam int IPX_RC_PRIO_EN = 7;
  localparam int IPX_RC_WDT_TO = 3;
  localparam int IPX_RC_PWRDN = 2;
  localparam int IPX_MN_GIE_HI = 7;
  localparam int IPX_MN_GIE_LO = 6;
  localparam int IPX_MN_T0_EN = 5;
  localparam int IPX_MN_EXT0_EN = 4;
  localparam int IPX_MN_RB_EN = 3;
  localparam int IPX_MN_T0_FLAG = 2;
  localparam int IPX_MN_EXT0_FLAG = 1;
  localparam int IPX_MN_RB_FLAG = 0;
  localparam int IPX_SC_EDGE0 = 7;
  localparam int IPX_SC_T0_PRIO = 2;
  localparam int IPX_SC_EXT3_PRIO = 1;
  localparam int IPX_SC_RB_PRIO = 0;
  localparam int IPX_TC_EXT2_PRIO = 7;
  localparam int IPX_TC_EXT1_PRIO = 6;
  localparam int IPX_TC_EXT1_EN = 3;
  localparam int IPX_TC_EXT1_FLAG = 0;
  // ==========================================================
  // Timer rollover values and stack geometry
  localparam logic [7:0] IPX_T0_MAX8 = 8'hff;
  localparam logic [15:0] IPX_T0_MAX16 = 16'hffff;
  localparam int IPX_PC_W = 21;
  localparam int IPX_STK_DEPTH = 31;
  localparam int IPX_SP_W = 5;

  typedef enum logic [1:0] {
    IPX_RUN,
    IPX_LOW,
    IPX_HIGH,
    IPX_HIGH_OVER_LOW
  } ipx_svc_e;
endpackage

// ### src/ipx_irq_ctrl.sv
// Interrupt priority controller with external pin, timer and port change sources
// Notes on behaviour
// [RL1] Priority bits matter only when levels enabled
// [RL2] First priority register: eight bits, reset one
// [RL3] Second priority register, bits 5-4 read zero
// [RL4] Third register: serial-2 bits 5-4, capcmp3 bit 0
// [RL5] Reset-control bit 7 enables two levels
// [RL6] Reset-control also exposes reset cause bits
// [RL7] External pins trigger on selected edge
// [RL8] Valid edge sets flag; enable gates request
// [RL9] Software clears pin flag before re-enabling
// [RL10] Enabled pin interrupt wakes sleeping core
// [RL11] After wake, vector only if enabled globally
// [RL12] Pins 1-3 priority from control bits
// [RL13] Pin zero is always high priority
// [RL14] Timer0 rollover sets flag, 8/16-bit modes
// [RL15] Timer0 enable main bit 5, priority bit 2
// [RL16] Port-B upper change sets flag, gated, prioritised
// [RL17] Entry pushes PC and shadows context registers
// [RL18] Single level: peripherals need group enable
// [RL19] Enabled source picks vector by priority bit
// [RL20] High preempts low service, never reverse
`timescale 1ns/1ps
module ipx_irq_ctrl
  import ipx_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [3:0] ext_pin,
  input wire logic [15:0] timer0_count,
  input wire logic timer0_wide_mode,
  input wire logic [7:4] portb_pins,
  input wire logic [7:0] periph_flags1,
  input wire logic [7:0] periph_enables1,
  input wire logic [7:0] periph_flags2,
  input wire logic [7:0] periph_enables2,
  input wire logic [7:0] periph_flags3,
  input wire logic [7:0] periph_enables3,
  input wire logic watchdog_timeout_evt,
  input wire logic sleep_enter_evt,
  input wire logic watchdog_clear_evt,
  input wire logic core_sleeping,
  input wire logic core_boundary,
  input wire logic [IPX_PC_W-1:0] return_pc,
  input wire logic [7:0] working_register,
  input wire logic [7:0] status_register,
  input wire logic [7:0] bank_select_register,
  input wire logic irq_return,
  input wire logic irq_return_fast,
  output logic wake_core,
  output logic vector_take,
  output logic vector_high,
  output logic in_service,
  output logic ret_valid,
  output logic [IPX_PC_W-1:0] ret_pc,
  output logic restore_valid,
  output logic [7:0] shadow_working,
  output logic [7:0] shadow_status,
  output logic [7:0] shadow_bank_select
);
  import ipx_pkg::*;

  // ==========================================================
  // Bus slave
  logic [7:0] addr_q;
  logic wr_pend_q;
  logic rd_pend_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic ap_take;
  logic wr_main;
  logic wr_second;
  logic wr_third;
  logic [7:0] prio1_q;
  logic [7:0] prio2_q;
  logic [7:0] prio3_q;
  logic [7:0] rstctl_q;
  logic [7:0] main_ctl_q;
  logic [7:0] second_ctl_q;
  logic [7:0] third_ctl_q;

  assign ap_take = hsel & htrans[1] & hready;
  assign wr_main = wr_pend_q & (addr_q == IPX_OFF_MAIN);
  assign wr_second = wr_pend_q & (addr_q == IPX_OFF_SECOND);
  assign wr_third = wr_pend_q & (addr_q == IPX_OFF_THIRD);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q <= 8'h00;
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
    end else begin
      // Reads stall one cycle so a write just before is visible
      if (ap_take) begin
        addr_q <= {haddr[7:2], 2'b00};
      end
      wr_pend_q <= ap_take & hwrite;
      rd_pend_q <= ap_take & ~hwrite;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b1;
      hrdata_q <= 32'h0000_0000;
    end else begin
      hreadyout_q <= ~(ap_take & ~hwrite);
      if (rd_pend_q) begin
        case (addr_q)
          IPX_OFF_PRIO1: hrdata_q <= {24'h00_0000, prio1_q};
          IPX_OFF_PRIO2: hrdata_q <= {24'h00_0000, prio2_q & IPX_MASK_PRIO2}; // [RL3]
          IPX_OFF_PRIO3: hrdata_q <= {24'h00_0000, prio3_q & IPX_MASK_PRIO3}; // [RL4]
          IPX_OFF_RSTCTL: hrdata_q <= {24'h00_0000, rstctl_q}; // [RL6]
          IPX_OFF_MAIN: hrdata_q <= {24'h00_0000, main_ctl_q};
          IPX_OFF_SECOND: hrdata_q <= {24'h00_0000, second_ctl_q};
          IPX_OFF_THIRD: hrdata_q <= {24'h00_0000, third_ctl_q};
          default: hrdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0;

  // ==========================================================
  // Priority and reset-control registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prio1_q <= IPX_RST_PRIO1; // [RL2]
      prio2_q <= IPX_RST_PRIO2; // [RL3]
      prio3_q <= IPX_RST_PRIO3; // [RL4]
    end else if (wr_pend_q) begin
      if (addr_q == IPX_OFF_PRIO1) begin
        prio1_q <= hwdata[7:0]; // [RL2]
      end
      if (addr_q == IPX_OFF_PRIO2) begin
        prio2_q <= hwdata[7:0] & IPX_MASK_PRIO2; // [RL3]
      end
      if (addr_q == IPX_OFF_PRIO3) begin
        // Serial-2 priorities are read-only ones
        prio3_q <= (prio3_q & ~IPX_WMASK_PRIO3) | (hwdata[7:0] & IPX_WMASK_PRIO3); // [RL4]
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rstctl_q <= IPX_RST_RSTCTL; // [RL5] [RL6]
    end else begin
      if (wr_pend_q && addr_q == IPX_OFF_RSTCTL) begin
        rstctl_q[7:0] <= (rstctl_q & ~IPX_WMASK_RSTCTL) | (hwdata[7:0] & IPX_WMASK_RSTCTL); // [RL6]
      end
      // Hardware-only cause flags; a timeout or sleep event outranks a same-cycle watchdog clear
      if (watchdog_timeout_evt) begin
        rstctl_q[IPX_RC_WDT_TO] <= 1'b0; // [RL6]
      end else if (watchdog_clear_evt) begin
        rstctl_q[IPX_RC_WDT_TO] <= 1'b1;
      end
      if (sleep_enter_evt) begin
        rstctl_q[IPX_RC_PWRDN] <= 1'b0; // [RL6]
      end else if (watchdog_clear_evt) begin
        rstctl_q[IPX_RC_PWRDN] <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Event detection
  logic [3:0] ext_prev_q;
  logic [7:4] portb_prev_q;
  logic [15:0] t0_prev_q;
  logic [3:0] ext_edge_sel;
  logic [3:0] ext_evt;
  logic t0_evt;
  logic rb_evt;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_prev_q <= 4'h0;
      portb_prev_q <= 4'h0;
      t0_prev_q <= 16'h0000;
    end else begin
      ext_prev_q <= ext_pin;
      portb_prev_q <= portb_pins;
      t0_prev_q <= timer0_count;
    end
  end

  // Edge selects sit in descending order from the top of the second register
  assign ext_edge_sel = {second_ctl_q[IPX_SC_EDGE0-3], second_ctl_q[IPX_SC_EDGE0-2],
                         second_ctl_q[IPX_SC_EDGE0-1], second_ctl_q[IPX_SC_EDGE0]};
  assign ext_evt = (ext_edge_sel & ext_pin & ~ext_prev_q)
                 | (~ext_edge_sel & ~ext_pin & ext_prev_q); // [RL7]
  assign t0_evt = timer0_wide_mode
                ? (t0_prev_q == IPX_T0_MAX16 && timer0_count == 16'h0000)
                : (t0_prev_q[7:0] == IPX_T0_MAX8 && timer0_count[7:0] == 8'h00); // [RL14]
  // First cycle after reset compares against zero; a high pin looks like a change
  assign rb_evt = |(portb_pins ^ portb_prev_q); // [RL16]

  // ==========================================================
  // Control registers; a hardware set beats a same-cycle software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      main_ctl_q <= IPX_RST_MAIN;
    end else begin
      if (wr_main) begin
        main_ctl_q <= hwdata[7:0];
      end
      // Flags are never cleared by hardware; software must do it
      if (t0_evt) begin
        main_ctl_q[IPX_MN_T0_FLAG] <= 1'b1; // [RL14]
      end
      if (ext_evt[0]) begin
        main_ctl_q[IPX_MN_EXT0_FLAG] <= 1'b1; // [RL8] [RL9]
      end
      if (rb_evt) begin
        main_ctl_q[IPX_MN_RB_FLAG] <= 1'b1; // [RL16]
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      second_ctl_q <= IPX_RST_SECOND;
    end else if (wr_second) begin
      second_ctl_q <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      third_ctl_q <= IPX_RST_THIRD;
    end else begin
      if (wr_third) begin
        third_ctl_q <= hwdata[7:0];
      end
      for (int i = 1; i < 4; i++) begin
        if (ext_evt[i]) begin
          third_ctl_q[IPX_TC_EXT1_FLAG+i-1] <= 1'b1; // [RL8]
        end
      end
    end
  end

  // ==========================================================
  // Request resolution
  logic prio_en;
  logic [5:0] core_req;
  logic [5:0] core_prio;
  logic [23:0] per_req;
  logic [23:0] per_prio;
  logic any_req;
  logic hi_pend;
  logic lo_pend;

  assign prio_en = rstctl_q[IPX_RC_PRIO_EN]; // [RL5]
  // Source order: port-B change, timer0, pins 3..0
  assign core_req = {
    main_ctl_q[IPX_MN_RB_FLAG] & main_ctl_q[IPX_MN_RB_EN], // [RL16]
    main_ctl_q[IPX_MN_T0_FLAG] & main_ctl_q[IPX_MN_T0_EN], // [RL15]
    third_ctl_q[IPX_TC_EXT1_FLAG+2:IPX_TC_EXT1_FLAG]
      & third_ctl_q[IPX_TC_EXT1_EN+2:IPX_TC_EXT1_EN], // [RL8]
    main_ctl_q[IPX_MN_EXT0_FLAG] & main_ctl_q[IPX_MN_EXT0_EN] // [RL8]
  };
  assign core_prio = {
    second_ctl_q[IPX_SC_RB_PRIO], // [RL16]
    second_ctl_q[IPX_SC_T0_PRIO], // [RL15]
    second_ctl_q[IPX_SC_EXT3_PRIO], // [RL12]
    third_ctl_q[IPX_TC_EXT2_PRIO], // [RL12]
    third_ctl_q[IPX_TC_EXT1_PRIO], // [RL12]
    1'b1 // [RL13]
  };
  assign per_req = {periph_flags3 & periph_enables3 & IPX_MASK_PRIO3,
                    periph_flags2 & periph_enables2 & IPX_MASK_PRIO2,
                    periph_flags1 & periph_enables1};
  assign per_prio = {prio3_q, prio2_q, prio1_q};
  assign any_req = |core_req | |per_req;

  always_comb begin
    if (prio_en) begin
      // Each source lands on the vector its priority bit names
      hi_pend = |(core_req & core_prio) | |(per_req & per_prio); // [RL19]
      lo_pend = |(core_req & ~core_prio) | |(per_req & ~per_prio); // [RL19]
    end else begin
      // Priority bits ignored; one level on the high vector
      hi_pend = |core_req
              | (main_ctl_q[IPX_MN_GIE_LO] & |per_req); // [RL1] [RL18]
      lo_pend = 1'b0; // [RL1]
    end
  end

  // ==========================================================
  // Service level, stack and shadow
  ipx_svc_e svc_q;
  logic take_hi;
  logic take_lo;
  logic do_entry;
  logic do_return;
  logic [IPX_PC_W-1:0] stack_q [IPX_STK_DEPTH];
  logic [IPX_SP_W-1:0] sp_q;

  always_comb begin
    take_hi = 1'b0;
    take_lo = 1'b0;
    case (svc_q)
      IPX_RUN: begin
        take_hi = hi_pend & main_ctl_q[IPX_MN_GIE_HI]; // [RL11]
        take_lo = prio_en & lo_pend & main_ctl_q[IPX_MN_GIE_LO]; // [RL11]
      end
      IPX_LOW: take_hi = prio_en & hi_pend & main_ctl_q[IPX_MN_GIE_HI]; // [RL20]
      IPX_HIGH: take_hi = 1'b0; // [RL20]
      IPX_HIGH_OVER_LOW: take_hi = 1'b0;
      default: take_hi = 1'b0;
    endcase
  end

  // Return has precedence; entry waits a boundary. A full stack refuses entry.
  assign do_return = irq_return & (svc_q != IPX_RUN);
  assign do_entry = core_boundary & ~irq_return & ~core_sleeping & (take_hi | take_lo)
                  & (sp_q != IPX_SP_W'(IPX_STK_DEPTH));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      svc_q <= IPX_RUN;
    end else if (do_return) begin
      case (svc_q)
        IPX_HIGH_OVER_LOW: svc_q <= IPX_LOW;
        default: svc_q <= IPX_RUN;
      endcase
    end else if (do_entry) begin
      if (take_hi) begin
        svc_q <= (svc_q == IPX_LOW) ? IPX_HIGH_OVER_LOW : IPX_HIGH; // [RL20]
      end else begin
        svc_q <= IPX_LOW;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sp_q <= '0;
      ret_pc <= '0;
      ret_valid <= 1'b0;
    end else begin
      ret_valid <= do_return;
      if (do_entry) begin
        sp_q <= sp_q + 1'b1; // [RL17]
      end else if (do_return && sp_q != '0) begin
        sp_q <= sp_q - 1'b1;
        ret_pc <= stack_q[sp_q - 1'b1];
      end
    end
  end

  // Stack storage needs no reset; contents are only read after a push
  always_ff @(posedge hclk) begin
    if (do_entry) begin
      stack_q[sp_q] <= return_pc; // [RL17]
    end
  end

  // Single shadow set: a nested entry overwrites the low routine's copy
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shadow_working <= 8'h00;
      shadow_status <= 8'h00;
      shadow_bank_select <= 8'h00;
      restore_valid <= 1'b0;
    end else begin
      restore_valid <= do_return & irq_return_fast;
      if (do_entry) begin
        shadow_working <= working_register; // [RL17]
        shadow_status <= status_register; // [RL17]
        shadow_bank_select <= bank_select_register; // [RL17]
      end
    end
  end

  // ==========================================================
  // Core-facing outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_core <= 1'b0;
      vector_take <= 1'b0;
      vector_high <= 1'b0;
      in_service <= 1'b0;
    end else begin
      // Wake ignores global enables; vectoring then depends on them
      wake_core <= core_sleeping & any_req; // [RL10]
      vector_take <= do_entry; // [RL11]
      if (do_entry) begin
        vector_high <= take_hi; // [RL19]
      end
      in_service <= (do_entry | (svc_q != IPX_RUN)) & ~(do_return && svc_q != IPX_HIGH_OVER_LOW);
    end
  end
endmodule

// ### verif/ipx_irq_ctrl_props.sv
// Assertion checker for the interrupt priority controller
`timescale 1ns/1ps
module ipx_irq_ctrl_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic core_sleeping,
  input wire logic core_boundary,
  input wire logic [7:0] working_register,
  input wire logic [7:0] status_register,
  input wire logic irq_return,
  input wire logic irq_return_fast,
  input wire logic wake_core,
  input wire logic vector_take,
  input wire logic vector_high,
  input wire logic in_service,
  input wire logic ret_valid,
  input wire logic restore_valid,
  input wire logic [7:0] shadow_working,
  input wire logic [7:0] shadow_status
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  wire logic acc = hsel && htrans[1] && hready;
  // ==========
  // Bus
  rd_wait_a: assert property (acc && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase wrong length");
  wr_nowait_a: assert property (acc && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  // ==========
  // Entry and return
  entry_gate_a: assert property (vector_take |-> $past(core_boundary) && !$past(core_sleeping))
    else $error("entry taken outside boundary or asleep");
  entry_service_a: assert property (vector_take |-> in_service)
    else $error("entry without service level");
  svc_rise_a: assert property ($rose(in_service) |-> vector_take)
    else $error("service level rose without entry");
  shadow_copy_a: assert property (vector_take |-> shadow_working == $past(working_register)
    && shadow_status == $past(status_register))
    else $error("shadow copy wrong");
  ret_cause_a: assert property (ret_valid |-> $past(irq_return) && $past(in_service))
    else $error("return without request in service");
  fast_ret_a: assert property (restore_valid |-> ret_valid && $past(irq_return_fast))
    else $error("restore without fast return");
  wake_cause_a: assert property (wake_core |-> $past(core_sleeping))
    else $error("wake while not sleeping");
  hi_cov: cover property (vector_take && vector_high);
  lo_cov: cover property (vector_take && !vector_high);
  fast_cov: cover property (restore_valid);
endmodule

bind ipx_irq_ctrl ipx_irq_ctrl_props i_props (
  .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp,
  .core_sleeping, .core_boundary, .working_register, .status_register,
  .irq_return, .irq_return_fast, .wake_core, .vector_take, .vector_high,
  .in_service, .ret_valid, .restore_valid, .shadow_working, .shadow_status
);

// ### verif/ipx_irq_ctrl_tb.sv
// Self-checking bench for the interrupt priority controller
`timescale 1ns/1ps
module ipx_irq_ctrl_tb;
  import ipx_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0;
  logic [3:0] ext_pin = 4'h0;
  logic [15:0] timer0_count = 16'h0;
  logic timer0_wide_mode = 1'b0;
  logic [7:4] portb_pins = 4'h0;
  logic [23:0] pf = 24'h0;
  logic [23:0] pe = 24'h0;
  logic watchdog_timeout_evt = 1'b0;
  logic sleep_enter_evt = 1'b0;
  logic watchdog_clear_evt = 1'b0;
  logic core_sleeping = 1'b0;
  logic core_boundary = 1'b1;
  logic [IPX_PC_W-1:0] return_pc = 21'h0;
  logic [7:0] working_register = 8'h0;
  logic [7:0] status_register = 8'h0;
  logic [7:0] bank_select_register = 8'h0;
  logic irq_return = 1'b0;
  logic irq_return_fast = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, wake_core, vector_take, vector_high, in_service;
  logic ret_valid, restore_valid;
  logic [IPX_PC_W-1:0] ret_pc;
  logic [7:0] shadow_working, shadow_status, shadow_bank_select;
  int bad_count = 0;
  int samples_checked = 0;

  ipx_irq_ctrl i_dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .ext_pin, .timer0_count,
    .timer0_wide_mode, .portb_pins,
    .periph_flags1(pf[7:0]), .periph_enables1(pe[7:0]),
    .periph_flags2(pf[15:8]), .periph_enables2(pe[15:8]),
    .periph_flags3(pf[23:16]), .periph_enables3(pe[23:16]),
    .watchdog_timeout_evt, .sleep_enter_evt, .watchdog_clear_evt, .core_sleeping,
    .core_boundary, .return_pc, .working_register, .status_register,
    .bank_select_register, .irq_return, .irq_return_fast, .wake_core, .vector_take,
    .vector_high, .in_service, .ret_valid, .ret_pc, .restore_valid, .shadow_working,
    .shadow_status, .shadow_bank_select
  );

  initial begin
    forever #20 hclk = ~hclk;
  end

  // ==========
  // Helpers
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // Waits are bounded so a stuck slave cannot hang the run
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] wd,
                      output logic [31:0] rd);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 50) begin
      n++;
      @(posedge hclk);
    end
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 50) begin
      n++;
      @(posedge hclk);
    end
    if (n >= 50) bad_count++;
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] x;
    xfer(a, 1'b1, d, x);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] x;
    xfer(a, 1'b0, 8'h00, x);
    chk(x, {24'h0, e});
  endtask

  task automatic take(input logic et, input logic eh);
    logic got;
    got = 1'b0;
    // Look just after each edge so the one-cycle pulse is settled
    repeat (6) begin
      @(posedge hclk);
      #1;
      if (vector_take === 1'b1) got = 1'b1;
    end
    chk(32'(got), 32'(et));
    if (et) chk(32'(vector_high), 32'(eh));
    @(posedge hclk);
  endtask

  task automatic ret(input logic es);
    irq_return <= 1'b1;
    irq_return_fast <= 1'b1;
    @(posedge hclk);
    irq_return <= 1'b0;
    irq_return_fast <= 1'b0;
    // Return pulses stand for the cycle after the accepting edge
    #1;
    chk({30'h0, ret_valid, restore_valid}, 32'h3);
    chk(32'(ret_pc), 32'h1abcd);
    chk(32'(in_service), 32'(es));
    @(posedge hclk);
  endtask

  // ==========
  // Scenarios
  task automatic t_regs();
    rd(8'h00, 8'hff);
    rd(8'h04, 8'hcf);
    rd(8'h08, 8'h31);
    rd(8'h0c, 8'h5c);
    wr(8'h00, 8'h00);
    rd(8'h00, 8'h00);
    wr(8'h04, 8'hff);
    rd(8'h04, 8'hcf);
    wr(8'h08, 8'h00);
    rd(8'h08, 8'h30);
    wr(8'h0c, 8'hff);
    rd(8'h0c, 8'hdf);
    wr(8'h3c, 8'hff);
    rd(8'h3c, 8'h00);
    watchdog_timeout_evt <= 1'b1;
    cyc(1);
    watchdog_timeout_evt <= 1'b0;
    sleep_enter_evt <= 1'b1;
    cyc(1);
    sleep_enter_evt <= 1'b0;
    cyc(1);
    rd(8'h0c, 8'hd3);
    wr(8'h0c, 8'h80);
    $display("done registers");
  endtask

  task automatic t_ext();
    ext_pin <= 4'hf;
    cyc(3);
    rd(8'h10, 8'h02);
    rd(8'h18, 8'hc7);
    wr(8'h10, 8'h00);
    wr(8'h18, 8'hc0);
    wr(8'h14, 8'h07);
    ext_pin <= 4'h0;
    cyc(3);
    rd(8'h10, 8'h02);
    rd(8'h18, 8'hc7);
    wr(8'h10, 8'h00);
    wr(8'h18, 8'hc0);
    ext_pin <= 4'hf;
    cyc(3);
    rd(8'h10, 8'h00);
    rd(8'h18, 8'hc0);
    wr(8'h14, 8'hf7);
    ext_pin <= 4'h0;
    $display("done pins");
  endtask

  task automatic t_tmr();
    timer0_count <= 16'h00ff;
    cyc(2);
    timer0_count <= 16'h0000;
    cyc(3);
    rd(8'h10, 8'h04);
    wr(8'h10, 8'h00);
    timer0_wide_mode <= 1'b1;
    timer0_count <= 16'h00ff;
    cyc(2);
    timer0_count <= 16'h0100;
    cyc(3);
    rd(8'h10, 8'h00);
    timer0_count <= 16'hffff;
    cyc(2);
    timer0_count <= 16'h0000;
    cyc(3);
    rd(8'h10, 8'h04);
    wr(8'h10, 8'h00);
    portb_pins <= 4'h8;
    cyc(3);
    rd(8'h10, 8'h01);
    wr(8'h10, 8'h00);
    $display("done timer and port");
  endtask

  task automatic t_vec();
    return_pc <= 21'h1abcd;
    working_register <= 8'h5a;
    status_register <= 8'h3c;
    bank_select_register <= 8'h0f;
    core_sleeping <= 1'b1;
    wr(8'h10, 8'hd0);
    ext_pin <= 4'h1;
    take(1'b0, 1'b0);
    chk(32'(wake_core), 32'h1);
    core_sleeping <= 1'b0;
    take(1'b1, 1'b1);
    chk({8'h0, shadow_working, shadow_status, shadow_bank_select}, 32'h005a3c0f);
    wr(8'h10, 8'hd0);
    ret(1'b0);
    pf[16] <= 1'b1;
    pe[16] <= 1'b1;
    take(1'b1, 1'b0);
    ext_pin <= 4'h0;
    cyc(2);
    ext_pin <= 4'h1;
    take(1'b1, 1'b1);
    take(1'b0, 1'b0);
    wr(8'h10, 8'hd0);
    ret(1'b1);
    pf[16] <= 1'b0;
    cyc(1);
    ret(1'b0);
    wr(8'h0c, 8'h00);
    wr(8'h10, 8'h80);
    pf[16] <= 1'b1;
    take(1'b0, 1'b0);
    wr(8'h10, 8'hc0);
    take(1'b1, 1'b1);
    pf[16] <= 1'b0;
    cyc(1);
    ret(1'b0);
    $display("done vectors");
  endtask

  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_ext();
    t_tmr();
    t_vec();
    final_report();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (6000) @(posedge hclk);
    bad_count++;
    final_report();
  end
endmodule
